/* File: hw/rtc_core.sv */
// Real-time clock: prescaler, time counter, alarm and power-down control
`timescale 1ns/1ps
`include "rtc_defs.svh"
// ======================================================================
// How it works
// - Count only on main or 32k oscillator edges
// - Keep counting in idle or power down unless oscillator off is requested
// - Cyclic irq every tick and every n
// - Prescaler plus counter give 58-bit timer
// - Wake from power down after programmed delay
// - Reference divided by fixed 64 first
// - Reload divider from period register each tick
// - Tick irq once per tick when enabled
// - Time counter steps per tick, software preloadable
// - Alarm irq when counter equals alarm
// - Route tick/alarm via select to wake input
// - Oscillator off in power down if requested
// - Disabled clock: both oscillators off in power down
// - 32k detected: use it, main off in power down
// - On 32k, keep running in stand-by
// - No 32k: main clocks, kept unless disabled or off requested
// - All registers reachable by software ports
module rtc_core #(
   parameter int PW = `RTC_PRESC_W,
   parameter int CW = `RTC_CNT_W
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic main_osc_in_i,
   input wire logic lowpower_osc_in_i,
   input wire logic rtc_enable_i,
   input wire logic powerdown_i,
   input wire logic standby_i,
   input wire logic osc_off_in_powerdown_i,
   input wire logic powerdown_wake_cfg_i,
   input wire logic tick_irq_en_i,
   input wire logic alarm_irq_en_i,
   input wire logic cyclic_irq_en_i,
   input wire logic [1:0] ext_irq_source_select_i,
   input wire logic tick_period_reload_wr_i,
   input wire logic [PW-1:0] tick_period_reload_wdata_i,
   input wire logic time_wr_i,
   input wire logic [CW-1:0] time_wdata_i,
   input wire logic alarm_wr_i,
   input wire logic [CW-1:0] alarm_wdata_i,
   input wire logic cyclic_n_wr_i,
   input wire logic [CW-1:0] cyclic_n_wdata_i,
   output logic [PW-1:0] tick_period_reload_o,
   output logic [CW-1:0] alarm_o,
   output logic [57:0] timer58_o,
   output logic lp_osc_detected_o,
   output rtc_pkg::rtc_irq_t irq_o,
   output logic ext_irq_o,
   output logic wake_o,
   output rtc_pkg::rtc_osc_t osc_o
);
   // ===================================================================
   // Source detection
   rtc_pkg::rtc_src_t src;
   rtc_pkg::rtc_src_t next_src;
   logic [7:0] det_cnt;
   logic lp_level;
   logic lp_rise;
   logic main_level;
   logic main_rise;
   logic osc_edge;
   rtc_edge_sync u_lp_sync (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .level_i(lowpower_osc_in_i),
      .rise_o(lp_rise),
      .level_o(lp_level)
   );
   rtc_edge_sync u_main_sync (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .level_i(main_osc_in_i),
      .rise_o(main_rise),
      .level_o(main_level)
   );
   // Detection window: a 32k edge before timeout selects it
   always_comb begin
      next_src = src;
      case (src)
         rtc_pkg::RTC_DETECT: begin
            if (lp_rise) begin
               next_src = rtc_pkg::RTC_RUN_LP;
            end else if (det_cnt == `RTC_DET_CNT) begin
               next_src = rtc_pkg::RTC_RUN_MAIN;
            end
         end
         rtc_pkg::RTC_RUN_LP: next_src = src;
         rtc_pkg::RTC_RUN_MAIN: next_src = src;
         default: next_src = rtc_pkg::RTC_DETECT;
      endcase
   end
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         src <= rtc_pkg::RTC_DETECT;
         det_cnt <= 8'h00;
      end else begin
         src <= next_src;
         det_cnt <= det_cnt + 8'h01;
      end
   end
   assign lp_osc_detected_o = (src == rtc_pkg::RTC_RUN_LP);
   // Oscillator edge only; never a gated system clock
   assign osc_edge = (src == rtc_pkg::RTC_RUN_LP) ? lp_rise :
      (src == rtc_pkg::RTC_RUN_MAIN) ? main_rise : 1'b0;
   // Stand-by: only the 32k source survives
   logic run;
   assign run = rtc_enable_i &
      (~standby_i | (src == rtc_pkg::RTC_RUN_LP)) &
      ~(powerdown_i & osc_off_in_powerdown_i);
   logic step;
   assign step = osc_edge & run;
   // ===================================================================
   // Registers
   logic [PW-1:0] period;
   logic [CW-1:0] alarm;
   logic [CW-1:0] cyc_n;
   rtc_load_reg #(.W(PW)) u_period (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .rst_val_i(`RTC_PRESC_RST),
      .wr_i(tick_period_reload_wr_i),
      .wdata_i(tick_period_reload_wdata_i),
      .q_o(period)
   );
   rtc_load_reg #(.W(CW)) u_alarm (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .rst_val_i(`RTC_ALARM_RST),
      .wr_i(alarm_wr_i),
      .wdata_i(alarm_wdata_i),
      .q_o(alarm)
   );
   rtc_load_reg #(.W(CW)) u_cyc (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .rst_val_i(`RTC_CNT_RST),
      .wr_i(cyclic_n_wr_i),
      .wdata_i(cyclic_n_wdata_i),
      .q_o(cyc_n)
   );
   assign tick_period_reload_o = period;
   assign alarm_o = alarm;
   // ===================================================================
   // Counter chain
   logic [5:0] prediv;
   logic [PW-1:0] divider;
   logic [CW-1:0] time_cnt;
   logic [CW-1:0] cyc_cnt;
   logic pre_wrap;
   logic tick;
   assign pre_wrap = step & (prediv == `RTC_PREDIV);
   assign tick = pre_wrap & (divider == '0);
   logic [CW-1:0] next_time;
   assign next_time = time_wr_i ? time_wdata_i :
      (tick ? time_cnt + 1'b1 : time_cnt);
   logic cyc_hit;
   assign cyc_hit = tick & (cyc_cnt == '0);
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         prediv <= '0;
         divider <= `RTC_PRESC_RST;
         time_cnt <= `RTC_CNT_RST;
         cyc_cnt <= `RTC_CNT_RST;
      end else begin
         if (step) begin
            prediv <= prediv + 6'h01;
         end
         if (tick) begin
            divider <= period;
         end else if (pre_wrap) begin
            divider <= divider - 1'b1;
         end
         time_cnt <= next_time;
         if (cyclic_n_wr_i || cyc_hit) begin
            cyc_cnt <= cyclic_n_wr_i ? cyclic_n_wdata_i : cyc_n;
         end else if (tick) begin
            cyc_cnt <= cyc_cnt - 1'b1;
         end
      end
   end
   // Divider counts down, so elapsed = period - divider
   logic [PW-1:0] elapsed;
   assign elapsed = period - divider;
   assign timer58_o = {time_cnt, elapsed, prediv};
   // ===================================================================
   // Interrupts and wake
   logic alarm_hit;
   assign alarm_hit = tick & (next_time == alarm);
   rtc_pkg::rtc_irq_t next_irq;
   assign next_irq.tick = tick & tick_irq_en_i;
   assign next_irq.alarm = alarm_hit & alarm_irq_en_i;
   assign next_irq.cyclic = cyclic_irq_en_i & (tick | cyc_hit);
   logic next_ext;
   assign next_ext = (ext_irq_source_select_i[0] & next_irq.tick) |
      (ext_irq_source_select_i[1] & next_irq.alarm);
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_o <= '0;
         ext_irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         irq_o <= next_irq;
         ext_irq_o <= next_ext;
         wake_o <= next_ext & powerdown_i & powerdown_wake_cfg_i;
      end
   end
   // ===================================================================
   // Oscillator control in power down
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         osc_o <= '0;
      end else begin
         osc_o.main_osc_off <= powerdown_i & (~rtc_enable_i |
            osc_off_in_powerdown_i | (src == rtc_pkg::RTC_RUN_LP));
         osc_o.lp_osc_off <= powerdown_i & (~rtc_enable_i |
            (osc_off_in_powerdown_i & (src == rtc_pkg::RTC_RUN_LP)));
      end
   end
   logic unused;
   assign unused = lp_level ^ main_level;
endmodule

/* File: common/rtc_defs.svh */
// Constants of the real-time clock block
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define RTC_PREDIV 6'h3f
`define RTC_PRESC_W 20
`define RTC_CNT_W 32
`define RTC_PRESC_RST 20'h00000
`define RTC_CNT_RST 32'h00000000
`define RTC_ALARM_RST 32'hffffffff
`define RTC_DET_CNT 8'hff
`endif

/* File: common/rtc_pkg.sv */
// Types of the real-time clock block
package rtc_pkg;
   typedef enum logic [1:0] {
      RTC_DETECT,
      RTC_RUN_LP,
      RTC_RUN_MAIN
   } rtc_src_t;
   typedef struct packed {
      logic tick;
      logic alarm;
      logic cyclic;
   } rtc_irq_t;
   typedef struct packed {
      logic main_osc_off;
      logic lp_osc_off;
   } rtc_osc_t;
endpackage

/* File: hw/rtc_edge_sync.sv */
// Two-stage synchroniser with single-cycle pulse on a rising level
`timescale 1ns/1ps
module rtc_edge_sync (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic level_i,
   output logic rise_o,
   output logic level_o
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= level_i;
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign rise_o = s2 & ~s3;
   assign level_o = s2;
endmodule

/* File: hw/rtc_load_reg.sv */
// Loadable register with write strobe, parameterised width
`timescale 1ns/1ps
module rtc_load_reg #(
   parameter int W = 32
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] rst_val_i,
   input wire logic wr_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] q;
   logic [W-1:0] next_q;
   // Stored relative to the reset value, so readback equals the write
   assign next_q = wr_i ? (wdata_i ^ rst_val_i) : q;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   assign q_o = q ^ rst_val_i;
endmodule

/* File: testbench/rtc_core_chk.sv */
// Port checker of the real-time clock core
`timescale 1ns/1ps
module rtc_core_chk #(
   parameter int PW = 20,
   parameter int CW = 32
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic rtc_enable_i,
   input wire logic powerdown_i,
   input wire logic osc_off_in_powerdown_i,
   input wire logic powerdown_wake_cfg_i,
   input wire logic tick_irq_en_i,
   input wire logic cyclic_irq_en_i,
   input wire logic tick_period_reload_wr_i,
   input wire logic [PW-1:0] tick_period_reload_wdata_i,
   input wire logic time_wr_i,
   input wire logic alarm_wr_i,
   input wire logic [CW-1:0] alarm_wdata_i,
   input wire logic [PW-1:0] tick_period_reload_o,
   input wire logic [CW-1:0] alarm_o,
   input wire logic [57:0] timer58_o,
   input wire logic lp_osc_detected_o,
   input wire rtc_pkg::rtc_irq_t irq_o,
   input wire logic wake_o,
   input wire rtc_pkg::rtc_osc_t osc_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================
   // Idle spans
   sequence s_off3;
      (!rtc_enable_i && !time_wr_i)[*3];
   endsequence
   // ==========================================
   // Assertions
   a_irq_one_cycle: assert property (irq_o.tick |=> !irq_o.tick)
      else $error("tick pulse too long");
   a_tick_needs_en: assert property (irq_o.tick |-> $past(tick_irq_en_i))
      else $error("tick pulse while masked");
   a_cyclic_each_tick: assert property
      (irq_o.tick && $past(cyclic_irq_en_i) |-> irq_o.cyclic)
      else $error("cyclic missing on tick");
   a_alarm_on_match: assert property
      (irq_o.alarm |-> timer58_o[57:26] == alarm_o)
      else $error("alarm without match");
   a_period_readback: assert property (tick_period_reload_wr_i |=>
      tick_period_reload_o == $past(tick_period_reload_wdata_i))
      else $error("period readback");
   a_alarm_readback: assert property
      (alarm_wr_i |=> alarm_o == $past(alarm_wdata_i))
      else $error("alarm readback");
   a_wake_in_pd: assert property
      (wake_o |-> $past(powerdown_wake_cfg_i) && $past(powerdown_i))
      else $error("wake outside power down");
   a_stop_disabled: assert property
      (s_off3 |-> $stable(timer58_o[57:26]))
      else $error("counting while disabled");
   a_osc_off_req: assert property
      (powerdown_i && osc_off_in_powerdown_i && !lp_osc_detected_o
      |=> osc_o.main_osc_off)
      else $error("oscillator kept on");
   a_both_osc_off: assert property
      (!rtc_enable_i && powerdown_i |=> osc_o == 2'h3)
      else $error("oscillators kept on");
endmodule
bind rtc_core rtc_core_chk #(.PW(PW), .CW(CW)) u_chk (.sys_clk_i,
   .sys_rst_i, .rtc_enable_i, .powerdown_i, .osc_off_in_powerdown_i,
   .powerdown_wake_cfg_i, .tick_irq_en_i, .cyclic_irq_en_i,
   .tick_period_reload_wr_i, .tick_period_reload_wdata_i, .time_wr_i,
   .alarm_wr_i, .alarm_wdata_i, .tick_period_reload_o, .alarm_o,
   .timer58_o, .lp_osc_detected_o, .irq_o, .wake_o, .osc_o);

/* File: testbench/rtc_core_tb.sv */
// Self-checking bench of the real-time clock core
`timescale 1ns/1ps
module rtc_core_tb;
   logic sys_clk_i = 0, sys_rst_i = 1, mosc = 0, en = 1, pd = 0, off = 0;
   logic wcfg = 1, pwr = 0, twr = 0, awr = 0, nwr = 0;
   logic [1:0] sel = 2'h1;
   logic [19:0] per = 20'h00000;
   logic [31:0] tv = 32'h0, av = 32'h0, nv = 32'h0;
   logic [19:0] per_o;
   logic [31:0] alm_o, tp;
   logic [57:0] t58;
   logic lpdet, ext, wake;
   rtc_pkg::rtc_irq_t irq;
   rtc_pkg::rtc_osc_t osc;
   int num_errors = 0, checks = 0, cyc = 0, last = 0, gap = 0;
   int n_tick = 0, n_alm = 0, n_ext = 0, n_wake = 0;
   rtc_core u_dut (.sys_clk_i, .sys_rst_i, .main_osc_in_i(mosc),
      .lowpower_osc_in_i(1'b0), .rtc_enable_i(en), .powerdown_i(pd),
      .standby_i(1'b0), .osc_off_in_powerdown_i(off),
      .powerdown_wake_cfg_i(wcfg), .tick_irq_en_i(1'b1),
      .alarm_irq_en_i(1'b1), .cyclic_irq_en_i(1'b1),
      .ext_irq_source_select_i(sel), .tick_period_reload_wr_i(pwr),
      .tick_period_reload_wdata_i(per), .time_wr_i(twr),
      .time_wdata_i(tv), .alarm_wr_i(awr), .alarm_wdata_i(av),
      .cyclic_n_wr_i(nwr), .cyclic_n_wdata_i(nv),
      .tick_period_reload_o(per_o), .alarm_o(alm_o), .timer58_o(t58),
      .lp_osc_detected_o(lpdet), .irq_o(irq), .ext_irq_o(ext),
      .wake_o(wake), .osc_o(osc));
   // ==========================================
   // Clocks and event monitor
   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      forever #16 mosc = ~mosc;
   end
   always @(posedge sys_clk_i) begin
      cyc++;
      n_alm += (irq.alarm === 1'b1);
      n_ext += (ext === 1'b1);
      n_wake += (wake === 1'b1);
      if (irq.tick === 1'b1) begin
         n_tick++;
         gap = cyc - last;
         last = cyc;
      end
   end
   // ==========================================
   // Tasks
   task chk(input logic [57:0] got, input logic [57:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task wr(input int k, input logic [31:0] d);
      @(posedge sys_clk_i);
      #1;
      case (k)
         0: {per, pwr} = {d[19:0], 1'b1};
         1: {tv, twr} = {d, 1'b1};
         2: {av, awr} = {d, 1'b1};
         default: {nv, nwr} = {d, 1'b1};
      endcase
      @(posedge sys_clk_i);
      #1;
      {pwr, twr, awr, nwr} = 4'h0;
   endtask
   task wait_tick;
      int n;
      n = n_tick;
      for (int i = 0; i < 3000 && n_tick == n; i++) @(posedge sys_clk_i);
      #1;
   endtask
   task run(input int c);
      repeat (c) @(posedge sys_clk_i);
      #1;
   endtask
   task end_sim;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      run(10);
      sys_rst_i = 0;
      chk(alm_o, 32'hffffffff);
      run(300);
      chk(lpdet, 1'b0);
      wr(3, 32'h3);
      wr(0, 32'h0);
      wr(1, 32'h10);
      wr(2, 32'h12);
      wait_tick;
      wait_tick;
      chk(gap, 256);
      chk(t58[57:26], 32'h12);
      chk(n_alm, 1);
      chk(n_ext != 0, 1'b1);
      $display("test count done");
      wr(0, 32'h1);
      wait_tick;
      wait_tick;
      chk(gap, 512);
      chk(per_o, 20'h1);
      $display("test period done");
      pd = 1;
      tp = t58[57:26];
      wait_tick;
      chk(t58[57:26], tp + 32'h1);
      chk(n_wake != 0, 1'b1);
      off = 1;
      run(2);
      chk(osc.main_osc_off, 1'b1);
      tp = t58[57:26];
      run(1200);
      chk(t58[57:26], tp);
      {pd, off, en} = 3'h0;
      run(1200);
      chk(t58[57:26], tp);
      pd = 1;
      run(2);
      chk(osc, 2'h3);
      $display("test power done");
      end_sim;
   end
   initial begin
      #160000;
      num_errors++;
      end_sim;
   end
endmodule
